// ==== logic/bpo_map.svh ====
// offsets, field positions, reset values and timing counts of the backplane output block
// assumes a 20 MHz reference clock and a register port with byte addresses
// What this block does
// - 256/128/64/32 channels at 16/8/4/2 Mb/s
// - each output stream has its own rate
// - 32 Mb/s mode leaves streams 16-31 idle
// - four active-high per-slot buffer enable outputs
// - enable k covers streams with index mod 4 = k
// - in 32 Mb/s mode only streams 0-15
// - frame pulse 122 ns or 244 ns, width bit
// - classic or GCI frame pulse detected automatically
// - frame boundary on edge chosen by polarity bit
// - async active-low reset clears counters, outputs high impedance
`ifndef BPO_MAP_SVH
`define BPO_MAP_SVH
`define BPO_REF_MHZ 20
`define BPO_FP_WIDE_NS 244
`define BPO_FP_WIDE_CYC ((`BPO_FP_WIDE_NS * `BPO_REF_MHZ + 999) / 1000)
`define BPO_IDLE_RUN (4 * `BPO_FP_WIDE_CYC)
`define BPO_OFS_CTRL 8'h00
`define BPO_OFS_RATE_LO 8'h04
`define BPO_OFS_RATE_HI 8'h08
`define BPO_OFS_STATUS 8'h0c
`define BPO_CTRL_FPW 0
`define BPO_CTRL_POL 1
`define BPO_CTRL_MODE32 2
`define BPO_CTRL_RESET 3'h0
`define BPO_RATE_RESET 64'h0
`define BPO_NSTREAM 32
`define BPO_FIFO_DEPTH 16
`define BPO_IDLE_BYTE 8'hff
`endif

// ==== logic/bpo_pkg.sv ====
// types shared by the backplane output block
// assumes bpo_map.svh for all numeric constants
package bpo_pkg;
    // one byte for one output stream, queued toward the serial pins
    typedef struct packed {
        logic [4:0] stream; // target output stream
        logic drive; // byte is driven, else the slot rests
        logic [7:0] data; // byte, sent msb first
    } bpo_slot_t;
    // software control word
    typedef struct packed {
        logic mode32; // fixed 32 Mb/s on streams 0-15
        logic pol; // 1: boundary on rising master clock edge
        logic frame_pulse_width_sel; // 1: wide frame pulse
    } bpo_ctrl_t;
    // frame pulse style detector states
    typedef enum logic [2:0] {
        BPO_ST_HUNT = 3'b001,
        BPO_ST_CLASSIC = 3'b010,
        BPO_ST_GCI = 3'b100
    } bpo_style_t;
endpackage : bpo_pkg

// ==== logic/bpo_sync.sv ====
// two flip-flop synchroniser for pin inputs
// assumes inputs are asynchronous to ref_clk_i
`timescale 1ns/10ps
`default_nettype none
module bpo_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r; // first stage, read only by q_o
    // two stages, both cleared by reset
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= '0;
            q_o <= '0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule : bpo_sync
`default_nettype wire

// ==== logic/bpo_fifo.sv ====
// flip-flop fifo with valid/ready on both sides
// assumes one clock; push and pop may happen in the same cycle
`timescale 1ns/10ps
`default_nettype none
module bpo_fifo #(
    parameter int W = 14,
    parameter int D = 16
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [W-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] FULL = (AW+1)'(D);
    localparam logic [AW-1:0] LAST = AW'(D - 1);
    logic [W-1:0] mem_r [D]; // storage
    logic [AW-1:0] wr_r; // write index
    logic [AW-1:0] rd_r; // read index
    logic [AW:0] cnt_r; // fill level
    logic push;
    logic pop;
    assign in_ready_o = (cnt_r != FULL);
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o = mem_r[rd_r];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    // storage write
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem_r[wr_r] <= in_data_i;
        end
    end
    // indices and level
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == LAST) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == LAST) ? '0 : rd_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : bpo_fifo
`default_nettype wire

// ==== logic/bpo_top.sv ====
// backplane serial output side: 32 tdm streams, four buffer enables, frame timing
// assumes master clock and frame pulse arrive on pins, asynchronous to ref_clk_i
`timescale 1ns/10ps
`default_nettype none
`include "bpo_map.svh"
module bpo_top (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire bpo_pkg::bpo_slot_t slot_i,
    input wire logic slot_valid_i,
    output logic slot_ready_o,
    input wire logic master_clock_in_i,
    input wire logic frame_pulse_in_i,
    input wire logic backplane_output_rest_state_i,
    input wire logic output_drive_enable_i,
    output logic [31:0] backplane_serial_out_o,
    output logic [31:0] backplane_serial_out_oe_o,
    output logic [3:0] backplane_slot_buffer_enable_o,
    output logic [3:0] backplane_slot_buffer_enable_oe_o
);
    localparam int NS = `BPO_NSTREAM;
    localparam logic [7:0] IDLE_RUN = 8'(`BPO_IDLE_RUN);
    logic [3:0] pins_s; // synchronised pins
    logic mc_s, fp_s; // master clock and frame pulse levels
    logic rest_high_s, ode_s; // 1: rest driven high; output drive enable pin
    logic mc_d_r, fp_d_r; // master clock and frame pulse one cycle back
    bpo_pkg::bpo_ctrl_t ctrl_r; // control register
    logic [63:0] rate_r; // two rate bits per stream
    bpo_pkg::bpo_style_t style_r, style_nxt; // frame pulse style and its next value
    logic [7:0] run_r; // cycles frame pulse kept its level
    logic [1:0] fp_edges_r; // selected edges seen in this pulse
    logic [10:0] tick_cnt_r, tick_cnt_nxt; // half master clock periods in frame, next
    logic frame_seen_r; // a boundary was found
    logic rise, fall, tick; // master clock edges: rising, falling, either
    logic sel_edge; // edge that may carry the boundary
    logic fp_active; // frame pulse asserted in its own style
    logic boundary; // frame boundary this cycle
    logic [1:0] need_edges; // edges the pulse width calls for
    logic [7:0] shift_r [NS]; // per stream shift register
    logic [NS-1:0] drive_r; // current slot is driven
    logic [7:0] hold_r [NS]; // next byte per stream
    logic [NS-1:0] hold_drv_r; // next byte drive flag
    logic [NS-1:0] hold_v_r; // next byte present
    logic [NS-1:0] load, step; // byte and bit boundaries per stream
    logic [NS-1:0] usable; // stream may carry data
    bpo_pkg::bpo_slot_t head; // fifo head
    logic head_v, pop, drop; // head present, head taken, head discarded
    logic fifo_full;
    logic [3:0] grp_drive; // any driving stream per enable group

    // shift count of a rate code: 16 Mb/s is one tick per bit
    function automatic logic [1:0] rate_shift(input logic [1:0] code);
        return 2'h3 - code;
    endfunction : rate_shift
    // true when the tick count starts a byte of this stream
    function automatic logic byte_start(input logic [10:0] cnt, input logic m32,
                                        input logic [1:0] code);
        logic [10:0] mask;
        mask = 11'((11'h8 << rate_shift(code)) - 11'h1);
        return m32 ? (cnt[1:0] == 2'h0) : ((cnt & mask) == 11'h0);
    endfunction : byte_start
    // true when the tick count starts a bit of this stream
    function automatic logic bit_start(input logic [10:0] cnt, input logic m32,
                                       input logic [1:0] code);
        logic [10:0] mask;
        mask = 11'((11'h1 << rate_shift(code)) - 11'h1);
        return m32 | ((cnt & mask) == 11'h0);
    endfunction : bit_start
    // pin synchroniser
    bpo_sync #(
        .W(4)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .d_i({output_drive_enable_i, backplane_output_rest_state_i,
              frame_pulse_in_i, master_clock_in_i}),
        .q_o(pins_s)
    );
    assign mc_s = pins_s[0];
    assign fp_s = pins_s[1];
    assign rest_high_s = pins_s[2];
    assign ode_s = pins_s[3];
    // byte queue toward the streams
    bpo_fifo #(
        .W($bits(bpo_pkg::bpo_slot_t)),
        .D(`BPO_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .in_data_i(slot_i),
        .in_valid_i(slot_valid_i),
        .in_ready_o(slot_ready_o),
        .out_data_o(head),
        .out_valid_o(head_v),
        .out_ready_i(pop)
    );
    assign fifo_full = ~slot_ready_o;
    // register writes
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_r <= `BPO_CTRL_RESET;
            rate_r <= `BPO_RATE_RESET;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `BPO_OFS_CTRL: begin
                    ctrl_r.frame_pulse_width_sel <= reg_wdata_i[`BPO_CTRL_FPW];
                    ctrl_r.pol <= reg_wdata_i[`BPO_CTRL_POL];
                    ctrl_r.mode32 <= reg_wdata_i[`BPO_CTRL_MODE32];
                end
                `BPO_OFS_RATE_LO: rate_r[31:0] <= reg_wdata_i;
                `BPO_OFS_RATE_HI: rate_r[63:32] <= reg_wdata_i;
                default: ;
            endcase
        end
    end
    // register reads, one cycle later, zero elsewhere
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 32'h0;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `BPO_OFS_CTRL: reg_rdata_o <= {29'h0, ctrl_r.mode32, ctrl_r.pol, ctrl_r.frame_pulse_width_sel};
                `BPO_OFS_RATE_LO: reg_rdata_o <= rate_r[31:0];
                `BPO_OFS_RATE_HI: reg_rdata_o <= rate_r[63:32];
                `BPO_OFS_STATUS: reg_rdata_o <= {27'h0, fifo_full, ~head_v, frame_seen_r,
                                                 style_r == bpo_pkg::BPO_ST_GCI,
                                                 style_r != bpo_pkg::BPO_ST_HUNT};
                default: reg_rdata_o <= 32'h0;
            endcase
        end
    end
    // edge detection on the synchronised master clock and frame pulse
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mc_d_r <= 1'b0;
            fp_d_r <= 1'b0;
        end else begin
            mc_d_r <= mc_s;
            fp_d_r <= fp_s;
        end
    end
    assign rise = mc_s & ~mc_d_r;
    assign fall = ~mc_s & mc_d_r;
    assign tick = rise | fall;
    assign sel_edge = ctrl_r.pol ? rise : fall;
    // run length of the frame pulse level; the long level is the idle level
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_r <= 8'h0;
        end else if (fp_s != fp_d_r) begin
            run_r <= 8'h0;
        end else if (run_r != IDLE_RUN) begin
            run_r <= run_r + 8'h1;
        end
    end
    // style choice: idle high means classic, idle low means gci
    always_comb begin
        style_nxt = style_r;
        if (run_r == IDLE_RUN) begin
            style_nxt = fp_s ? bpo_pkg::BPO_ST_CLASSIC : bpo_pkg::BPO_ST_GCI;
        end
    end
    // style state, re-detected whenever the idle level changes
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            style_r <= bpo_pkg::BPO_ST_HUNT;
        end else begin
            case (style_r)
                bpo_pkg::BPO_ST_HUNT: style_r <= style_nxt;
                bpo_pkg::BPO_ST_CLASSIC: style_r <= style_nxt;
                bpo_pkg::BPO_ST_GCI: style_r <= style_nxt;
                default: style_r <= bpo_pkg::BPO_ST_HUNT;
            endcase
        end
    end
    assign fp_active = ((style_r == bpo_pkg::BPO_ST_CLASSIC) & ~fp_s) |
                       ((style_r == bpo_pkg::BPO_ST_GCI) & fp_s);
    // boundary on the first selected edge, or the second for a wide pulse
    assign need_edges = ctrl_r.frame_pulse_width_sel ? 2'h2 : 2'h1;
    assign boundary = fp_active & sel_edge & ((fp_edges_r + 2'h1) == need_edges);
    // selected edges counted while the pulse lasts
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fp_edges_r <= 2'h0;
        end else if (!fp_active) begin
            fp_edges_r <= 2'h0;
        end else if (sel_edge && fp_edges_r != 2'h2) begin
            fp_edges_r <= fp_edges_r + 2'h1;
        end
    end
    // frame position in master clock half periods, 2048 per frame
    assign tick_cnt_nxt = boundary ? 11'h0 : tick_cnt_r + 11'h1;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_cnt_r <= 11'h0;
            frame_seen_r <= 1'b0;
        end else if (tick) begin
            tick_cnt_r <= tick_cnt_nxt;
            frame_seen_r <= frame_seen_r | boundary;
        end
    end
    // byte and bit boundaries of every stream at its own rate
    always_comb begin
        for (int s = 0; s < NS; s++) begin
            usable[s] = ~(ctrl_r.mode32 & (s >= 16));
            load[s] = tick & byte_start(tick_cnt_nxt, ctrl_r.mode32, rate_r[2*s +: 2]);
            step[s] = tick & bit_start(tick_cnt_nxt, ctrl_r.mode32, rate_r[2*s +: 2]);
        end
    end
    // fifo drain: bytes for unused streams are thrown away
    assign drop = ctrl_r.mode32 & head.stream[4];
    assign pop = head_v & (drop | ~hold_v_r[head.stream]);
    // next-byte holding registers; a byte arriving wins over the load
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_v_r <= '0;
            hold_drv_r <= '0;
            for (int s = 0; s < NS; s++) begin
                hold_r[s] <= 8'h0;
            end
        end else begin
            for (int s = 0; s < NS; s++) begin
                if (pop && !drop && head.stream == 5'(s)) begin
                    hold_v_r[s] <= 1'b1;
                    hold_drv_r[s] <= head.drive;
                    hold_r[s] <= head.data;
                end else if (load[s]) begin
                    hold_v_r[s] <= 1'b0;
                end
            end
        end
    end
    // shift registers: load at the byte boundary, shift at each bit
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drive_r <= '0;
            for (int s = 0; s < NS; s++) begin
                shift_r[s] <= `BPO_IDLE_BYTE;
            end
        end else begin
            for (int s = 0; s < NS; s++) begin
                if (load[s]) begin
                    shift_r[s] <= hold_v_r[s] ? hold_r[s] : `BPO_IDLE_BYTE;
                    drive_r[s] <= hold_v_r[s] & hold_drv_r[s] & usable[s];
                end else if (step[s]) begin
                    shift_r[s] <= ctrl_r.mode32 ? {shift_r[s][5:0], 2'h3}
                                                : {shift_r[s][6:0], 1'b1};
                end
            end
        end
    end
    // group drive: stream s belongs to enable s mod 4
    always_comb begin
        grp_drive = 4'h0;
        for (int s = 0; s < NS; s++) begin
            grp_drive[s % 4] = grp_drive[s % 4] | (drive_r[s] & usable[s]);
        end
    end

    // pins: driven data, else rest high or high impedance; unused streams rest
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            backplane_serial_out_o <= '1;
            backplane_serial_out_oe_o <= '0;
            backplane_slot_buffer_enable_o <= 4'h0;
            backplane_slot_buffer_enable_oe_o <= 4'h0;
        end else begin
            for (int s = 0; s < NS; s++) begin
                backplane_serial_out_o[s] <= ~(drive_r[s] & usable[s] & ode_s) | shift_r[s][7];
                backplane_serial_out_oe_o[s] <= (drive_r[s] & usable[s] & ode_s) | rest_high_s;
            end
            backplane_slot_buffer_enable_o <= grp_drive & {4{ode_s}};
            backplane_slot_buffer_enable_oe_o <= {4{ode_s | rest_high_s}};
        end
    end

    // checks
    sequence s_fp_edge;
        fp_active && sel_edge;
    endsequence
    property p_boundary_cause;
        @(posedge ref_clk_i) disable iff (!rst_n_i) boundary |-> s_fp_edge;
    endproperty
    a_boundary_cause: assert property (p_boundary_cause) else $error("boundary without pulse edge");
    property p_wide_second_edge;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
            (boundary && ctrl_r.frame_pulse_width_sel) |-> (fp_edges_r == 2'h1);
    endproperty
    a_wide_second_edge: assert property (p_wide_second_edge) else $error("wide pulse boundary early");
    property p_narrow_first_edge;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
            (s_fp_edge ##0 (fp_edges_r == 2'h0) ##0 !ctrl_r.frame_pulse_width_sel) |-> boundary;
    endproperty
    a_narrow_first_edge: assert property (p_narrow_first_edge) else $error("narrow pulse missed");
    property p_frame_restart;
        @(posedge ref_clk_i) disable iff (!rst_n_i) boundary |=> (tick_cnt_r == 11'h0);
    endproperty
    a_frame_restart: assert property (p_frame_restart) else $error("frame count not restarted");
    property p_pins_on_tick;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
            $changed(shift_r[0]) |-> $past(tick);
    endproperty
    a_pins_on_tick: assert property (p_pins_on_tick) else $error("stream moved off tick");
    property p_upper_idle;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
            ctrl_r.mode32 ##1 ctrl_r.mode32 |-> (backplane_serial_out_o[31:16] == 16'hffff);
    endproperty
    a_upper_idle: assert property (p_upper_idle) else $error("upper stream drove in 32 Mb/s mode");
    property p_enable_group;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
            backplane_slot_buffer_enable_o[1] |->
                $past(drive_r[1] | drive_r[5] | drive_r[9] | drive_r[13] | (usable[16] &
                      (drive_r[17] | drive_r[21] | drive_r[25] | drive_r[29]))) && $past(ode_s);
    endproperty
    a_enable_group: assert property (p_enable_group) else $error("enable without group drive");
    property p_enable_low_idle;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
            (drive_r == '0) |=> (backplane_slot_buffer_enable_o == 4'h0);
    endproperty
    a_enable_low_idle: assert property (p_enable_low_idle) else $error("enable high while idle");
    property p_style_level;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
            fp_active |-> (fp_s == (style_r == bpo_pkg::BPO_ST_GCI));
    endproperty
    a_style_level: assert property (p_style_level) else $error("active level wrong for style");
    property p_style_detect;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
            (run_r == IDLE_RUN) |=> (style_r == ($past(fp_s) ? bpo_pkg::BPO_ST_CLASSIC
                                                              : bpo_pkg::BPO_ST_GCI));
    endproperty
    a_style_detect: assert property (p_style_detect) else $error("style not taken from idle level");
endmodule : bpo_top
`default_nettype wire

// ==== tb/bpo_far_end.sv ====
// far side model: master clock and frame pulse source
// assumes the bench picks pulse style and width at run time
`timescale 1ns/10ps
`default_nettype none
module bpo_far_end (
    input wire logic gci_i,
    input wire logic wide_i,
    output logic mclk_o,
    output logic fp_o
);
    int cnt = 0; // master clock cycles into the frame
    logic act; // pulse asserted
    // continuous 8.192 MHz master clock
    initial begin
        mclk_o = 1'b0;
        forever #61.035 mclk_o = ~mclk_o;
    end
    // 1024 master clock cycles per 125 us frame
    always @(negedge mclk_o) cnt <= (cnt + 1) % 1024;
    // one or two clock periods wide at the boundary
    assign act = (cnt == 0) || (wide_i && cnt == 1);
    // classic style active low, gci active high
    assign fp_o = gci_i ? act : ~act;
endmodule : bpo_far_end
`default_nettype wire

// ==== tb/backplane_tdm_output_enable_test.sv ====
// bench for the backplane output block with a behavioural register and timing model
// assumes the far end model drives master clock and frame pulse
`timescale 1ns/10ps
`default_nettype none
`include "bpo_map.svh"
module backplane_tdm_output_enable_test;
    logic clk, rst_n, wr, rd, sv, sr, mclk, fp, rest, output_drive_enable, gci, wide, hit;
    logic [7:0] addr, d4;
    logic [31:0] wdata, rdata, so, soe, st;
    logic [3:0] en, enoe;
    bpo_pkg::bpo_slot_t slot;
    logic [31:0] mdl[4]; // register model
    int n[4];
    logic [7:0] b[4];
    int bad_count, check_count, cnt;
    bpo_top bpo_top_i (.ref_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .slot_i(slot), .slot_valid_i(sv), .slot_ready_o(sr), .master_clock_in_i(mclk),
        .frame_pulse_in_i(fp), .backplane_output_rest_state_i(rest),
        .output_drive_enable_i(output_drive_enable), .backplane_serial_out_o(so),
        .backplane_serial_out_oe_o(soe), .backplane_slot_buffer_enable_o(en),
        .backplane_slot_buffer_enable_oe_o(enoe));
    bpo_far_end bpo_far_end_i (.gci_i(gci), .wide_i(wide), .mclk_o(mclk), .fp_o(fp));
    // 20 MHz reference clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done;
        if (bad_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        if (a < 8'h0c) mdl[a[3:2]] = d;
        // one idle edge so a following strobe is never assigned twice in a step
        @(posedge clk);
    endtask : wr_reg
    // read data stand from the cycle after the strobe until the next read strobe
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask : rd_reg
    task automatic rd_chk(input logic [7:0] a);
        logic [31:0] d;
        rd_reg(a, d);
        // status right after reset: only the fifo empty flag is up
        chk(d, a == 8'h00 ? mdl[0] & 32'h7 : (a < 8'h0c ? mdl[a[3:2]] :
            (a == 8'h0c ? 32'h8 : 32'h0)));
    endtask : rd_chk
    task automatic push(input logic [4:0] s, input logic dr, input logic [7:0] d);
        slot <= {s, dr, d};
        sv <= 1'b1;
        do @(negedge clk); while (sr !== 1'b1);
        @(posedge clk);
        sv <= 1'b0;
        // idle edge before the next push raises valid again
        @(posedge clk);
    endtask : push
    // length of one enable pulse, stream k+4 sampled at the mid bit points of a 2 Mb/s byte
    task automatic run_len(input int k);
        int t;
        int i;
        t = 0;
        i = 0;
        n[k] = 0;
        while (en[k] !== 1'b1 && t < 9000) begin
            @(negedge clk);
            t++;
        end
        while (en[k] === 1'b1 && n[k] < 400) begin
            if (i < 8 && n[k] == (i * 9766 + 4883) / 1000) begin
                b[k][7-i] = so[k+4];
                i++;
            end
            @(negedge clk);
            n[k]++;
        end
    endtask : run_len
    task automatic rst_chk;
        @(negedge clk);
        chk(so, 32'hffffffff);
        chk({soe[27:0], en}, 32'h0);
        chk({rdata[26:0], enoe, sr}, 32'h1);
        mdl = '{default: 32'h0};
    endtask : rst_chk
    // watchdog
    initial begin
        #2000000;
        bad_count++;
        test_done();
    end
    initial begin
        {rst_n, wr, rd, sv, addr, wdata, slot, gci, wide} = '0;
        {rest, output_drive_enable} = 2'b11;
        bad_count = 0;
        check_count = 0;
        void'($urandom(32'hab5c));
        rst_chk();
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int a = 0; a < 24; a += 4) rd_chk(8'(a));
        wr_reg(8'h14, $urandom);
        rd_chk(8'h14);
        for (int a = 0; a < 12; a += 4) wr_reg(8'(a), $urandom);
        for (int a = 0; a < 12; a += 4) rd_chk(8'(a));
        wr_reg(8'h00, 32'h0);
        wr_reg(8'h04, 32'h0000e400);
        repeat (6000) @(posedge clk);
        rd_reg(8'h0c, st);
        chk(st[2:0], 3'b101);
        chk(soe, 32'hffffffff);
        chk(32'(enoe), 32'hf);
        {rest, output_drive_enable} <= 2'b00;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk({soe[27:0], enoe}, 32'h0);
        @(posedge clk);
        {rest, output_drive_enable} <= 2'b11;
        repeat (4) @(posedge clk);
        d4 = 8'($urandom);
        fork
            run_len(0);
            run_len(1);
            run_len(2);
            run_len(3);
            for (int s = 4; s < 8; s++) push(5'(s), 1'b1, s == 4 ? d4 : 8'h3c);
        join
        for (int k = 0; k < 4; k++) chk(32'(n[k] > (78125 >> k) / 1000 - 3
            && n[k] < (78125 >> k) / 1000 + 3), 32'h1);
        chk(b[0], d4);
        wr_reg(8'h00, 32'h4);
        push(5'd20, 1'b1, 8'h00);
        hit = 1'b0;
        repeat (300) begin
            @(negedge clk);
            if (en[0] !== 1'b0 || so[20] !== 1'b1) hit = 1'b1;
        end
        chk(32'(hit), 32'h0);
        @(posedge clk);
        fork
            run_len(0);
            push(5'd8, 1'b1, 8'h00);
        join
        chk(32'(n[0] > 2 && n[0] < 8), 32'h1);
        wr_reg(8'h00, 32'h0);
        // fill the fifo behind a slow stream
        cnt = 0;
        slot <= {5'd0, 1'b0, 8'($urandom)};
        sv <= 1'b1;
        while (cnt < 40) begin
            @(negedge clk);
            if (sr !== 1'b1) break;
            @(posedge clk);
            cnt++;
            slot <= {5'd0, 1'b0, 8'($urandom)};
        end
        @(posedge clk);
        sv <= 1'b0;
        chk(32'(cnt > 16 && cnt < 19), 32'h1);
        st = '0;
        cnt = 0;
        while (st[3] !== 1'b1 && cnt < 100) begin
            repeat (40) @(posedge clk);
            rd_reg(8'h0c, st);
            cnt++;
        end
        chk(st[4:3], 2'b01);
        gci <= 1'b1;
        wide <= 1'b1;
        wr_reg(8'h00, 32'h3);
        repeat (6000) @(posedge clk);
        rd_reg(8'h0c, st);
        chk(st[2:0], 3'b111);
        rst_n <= 1'b0;
        rst_chk();
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(8'h00);
        test_done();
    end
endmodule : backplane_tdm_output_enable_test
`default_nettype wire
